/* File: tmoc_pkg.sv */
/*
  shared constants and types of the two-instance output-compare timer.
  assumes an apb master with 32-bit data and one clock, clk_sys.
*/
`default_nettype none
package tmoc_pkg;
  typedef logic [31:0] tmoc_word_t;
  typedef logic [7:0] tmoc_addr_t;
  // per-timer configuration registers
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] ioab;
    logic [7:0] iocd;
  } tmoc_cfg_t;

  localparam int TMOC_NTMR = 2;
  localparam int TMOC_NPIN = 8;
  // common register byte offsets
  localparam tmoc_addr_t OFS_START = 8'h00;
  localparam tmoc_addr_t OFS_MODE = 8'h04;
  localparam tmoc_addr_t OFS_INIT = 8'h08;
  localparam tmoc_addr_t OFS_DIS = 8'h0C;
  localparam tmoc_addr_t OFS_PFN = 8'h10;
  // timer i block sits at 0x20 + i*0x20; word index inside the block
  localparam logic [2:0] SUB_CTRL = 3'h0;
  localparam logic [2:0] SUB_IOAB = 3'h1;
  localparam logic [2:0] SUB_IOCD = 3'h2;
  localparam logic [2:0] SUB_CNT = 3'h3;
  localparam logic [2:0] SUB_GRA = 3'h4;
  // start register fields
  localparam int START_RUN_LSB = 0;
  localparam int START_CONT_LSB = 2;
  // mode register fields
  localparam int MODE_SYNC = 0;
  localparam int MODE_BUF_LSB = 1;
  // control register fields
  localparam int CTRL_CKS_LSB = 0;
  localparam int CTRL_CLR_LSB = 3;
  localparam int CTRL_EDGE_LSB = 6;
  // pin function register: bits 7:0 compare output, bit 8 ext clock on pin a0
  localparam int PFN_EXT = 8;
  // count source codes
  localparam logic [2:0] CKS_DIV1 = 3'h0;
  localparam logic [2:0] CKS_DIV2 = 3'h1;
  localparam logic [2:0] CKS_DIV4 = 3'h2;
  localparam logic [2:0] CKS_DIV8 = 3'h3;
  localparam logic [2:0] CKS_DIV32 = 3'h4;
  localparam logic [2:0] CKS_EXT = 3'h5;
  // counter clear codes, low two bits
  localparam logic [1:0] CLR_ON_A = 2'h1;
  localparam logic [1:0] CLR_ON_B = 2'h2;
  // external edge codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  // compare actions, low two bits of each action code
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // reset values
  localparam logic [3:0] RST_START = 4'hC;
  localparam logic [4:0] RST_MODE = 5'h00;
  localparam logic [7:0] RST_INIT = 8'h00;
  localparam logic [7:0] RST_DIS = 8'hFF;
  localparam logic [8:0] RST_PFN = 9'h000;
  localparam tmoc_cfg_t RST_CFG = 24'h000000;
endpackage : tmoc_pkg
`default_nettype wire

/* File: tmoc_timer.sv */
/*
  two 16-bit up-counting timers in output-compare mode, four compare
  registers and four pins each, registers behind an apb slave.
  assumes pins are synchronous to clk_sys; port function muxing and
  tristate wire resolution live outside.
*/
// How it works
// - counter equal compare register drives configured level
// - count source clock, divided clock or ext edge
// - clear code 000 runs free, 65536 counts
// - clear codes 01/10 zero counter on match
// - writing run bit 1 starts the timer
// - continue set, run bit 0 stops, pins hold
// - continue clear, compare-a match stops the counter
// - every match and overflow raises an interrupt
// - counter read returns the current count
// - sync set loads both counters on write
// - per channel action low, high or invert
// - a/b code 011 toggles, 010 drives high
// - initial level from start until first match
// - compare ffff wraps and flags overflow
// - registers c/d can steer pins a/b
// - redirect needs select 0, buffer 0, distinct values
// - redirected c code 0011 inverts pin a
// - disable bit 0 lets the pin drive
// - buffer bits 1 make c/d plain compares
// - usable as internal timer without pins
// - pin a0 port, compare or ext clock
// - emergency cutoff pin unused in this mode
`timescale 1ns/1ps
`default_nettype none
module tmoc_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // apb slave
  input wire tmoc_pkg::tmoc_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tmoc_pkg::tmoc_word_t pwdata,
  output tmoc_pkg::tmoc_word_t prdata,
  output logic pready,
  output logic pslverr,
  // timer pins, index 4*i+j for timer i, channel a..d
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // interrupt requests, one-cycle pulses
  output logic [7:0] irq_match,
  output logic [1:0] irq_ovf
);
  import tmoc_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // apb and shared registers
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  tmoc_word_t prdata_r, prdata_nxt;
  logic [3:0] start_r, start_nxt;
  logic [4:0] mode_r, mode_nxt;
  logic [7:0] init_r, init_nxt, dis_r, dis_nxt;
  logic [8:0] pfn_r, pfn_nxt;
  logic [7:0] oe_r, oe_nxt;
  logic [4:0] pre_r, pre_nxt;
  logic ext_d_r, ext_d_nxt;
  // per-timer state
  tmoc_cfg_t cfg_r [TMOC_NTMR];
  logic [15:0] cnt_r [TMOC_NTMR];
  logic [15:0] gr_r [TMOC_NTMR][4];
  logic [3:0] lvl_r [TMOC_NTMR];
  logic [3:0] irqm_r [TMOC_NTMR];
  logic [TMOC_NTMR-1:0] ovf_r;
  logic [TMOC_NTMR-1:0] stop_w, start_w, cnt_wr_w, blk_hit_w;
  logic wr_go, cmn_hit, blk_sel;
  logic [2:0] sub;

  assign wr_go = psel & penable & pready_r & pwrite;
  assign cmn_hit = (paddr[7:5] == 3'h0);
  assign blk_sel = paddr[6];
  assign sub = paddr[4:2];
  assign blk_hit_w[0] = (paddr[7:5] == 3'h1);
  assign blk_hit_w[1] = (paddr[7:5] == 3'h2);

  // apb slave: answer in the first access cycle, data set up in setup cycle
  always_comb begin
    pready_nxt = psel & ~penable;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      prdata_nxt = 32'h0000_0000;
      if (cmn_hit) begin
        case (paddr)
          OFS_START: prdata_nxt[3:0] = start_r;
          OFS_MODE: prdata_nxt[4:0] = mode_r;
          OFS_INIT: prdata_nxt[7:0] = init_r;
          OFS_DIS: prdata_nxt[7:0] = dis_r;
          OFS_PFN: prdata_nxt[8:0] = pfn_r;
          default: pslverr_nxt = 1'b1;
        endcase
      end else if (blk_hit_w != 2'b00) begin
        case (sub)
          SUB_CTRL: prdata_nxt[7:0] = cfg_r[blk_sel].ctrl;
          SUB_IOAB: prdata_nxt[7:0] = cfg_r[blk_sel].ioab;
          SUB_IOCD: prdata_nxt[7:0] = cfg_r[blk_sel].iocd;
          SUB_CNT: prdata_nxt[15:0] = cnt_r[blk_sel];
          default: prdata_nxt[15:0] = gr_r[blk_sel][sub[1:0]];
        endcase
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // shared control registers, prescaler, pin enables
  always_comb begin
    start_nxt = start_r;
    mode_nxt = mode_r;
    init_nxt = init_r;
    dis_nxt = dis_r;
    pfn_nxt = pfn_r;
    start_w = '0;
    pre_nxt = 5'(pre_r + 5'h01);
    ext_d_nxt = pin_in[0];
    if (wr_go && cmn_hit) begin
      case (paddr)
        OFS_START: begin
          start_w = pwdata[1:0] & ~start_r[1:0];
          start_nxt = pwdata[3:0];
        end
        OFS_MODE: mode_nxt = pwdata[4:0];
        OFS_INIT: init_nxt = pwdata[7:0];
        OFS_DIS: dis_nxt = pwdata[7:0];
        OFS_PFN: pfn_nxt = pwdata[8:0];
        default: ;
      endcase
    end
    // a self-stop beats a same-cycle restart: the match already happened
    for (int i = 0; i < TMOC_NTMR; i++) begin
      if (stop_w[i]) begin
        start_nxt[START_RUN_LSB+i] = 1'b0;
      end
    end
    // disabled, port or ext-clock pins never drive
    oe_nxt = pfn_r[7:0] & ~dis_r;
    if (pfn_r[PFN_EXT]) begin
      oe_nxt[0] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      start_r <= RST_START;
      mode_r <= RST_MODE;
      init_r <= RST_INIT;
      dis_r <= RST_DIS;
      pfn_r <= RST_PFN;
      oe_r <= 8'h00;
      pre_r <= 5'h00;
      ext_d_r <= 1'b0;
    end else begin
      start_r <= start_nxt;
      mode_r <= mode_nxt;
      init_r <= init_nxt;
      dis_r <= dis_nxt;
      pfn_r <= pfn_nxt;
      oe_r <= oe_nxt;
      pre_r <= pre_nxt;
      ext_d_r <= ext_d_nxt;
    end
  end

  function automatic logic act(input logic [1:0] code, input logic cur);
    case (code)
      ACT_LOW: act = 1'b0;
      ACT_HIGH: act = 1'b1;
      ACT_TOGGLE: act = ~cur;
      default: act = cur;
    endcase
  endfunction : act

  // counter write hits the addressed timer, or both when synchronised
  always_comb begin
    for (int i = 0; i < TMOC_NTMR; i++) begin
      cnt_wr_w[i] = wr_go && (sub == SUB_CNT) &&
        (blk_hit_w[i] || (mode_r[MODE_SYNC] && blk_hit_w != 2'b00));
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < TMOC_NTMR; gi++) begin : g_tmr
      tmoc_cfg_t cfg_nxt;
      logic [15:0] cnt_nxt;
      logic [15:0] gr_nxt [4];
      logic [3:0] lvl_nxt, irqm_nxt, match;
      logic ovf_nxt, tick, cnt_en, clr, redir_c, redir_d;
      logic [2:0] cks;
      logic [1:0] edge_sel;
      logic ext_edge;

      assign cks = cfg_r[gi].ctrl[CTRL_CKS_LSB +: 3];
      assign edge_sel = cfg_r[gi].ctrl[CTRL_EDGE_LSB +: 2];
      assign redir_c = ~cfg_r[gi].iocd[3] & ~mode_r[MODE_BUF_LSB+2*gi];
      assign redir_d = ~cfg_r[gi].iocd[7] & ~mode_r[MODE_BUF_LSB+2*gi+1];
      assign stop_w[gi] = match[0] & ~start_r[START_CONT_LSB+gi];

      always_comb begin
        // source selection
        ext_edge = 1'b0;
        case (edge_sel)
          EDGE_RISE: ext_edge = pin_in[0] & ~ext_d_r;
          EDGE_FALL: ext_edge = ~pin_in[0] & ext_d_r;
          default: ext_edge = pin_in[0] ^ ext_d_r;
        endcase
        case (cks)
          CKS_DIV1: tick = 1'b1;
          CKS_DIV2: tick = pre_r[0];
          CKS_DIV4: tick = &pre_r[1:0];
          CKS_DIV8: tick = &pre_r[2:0];
          CKS_DIV32: tick = &pre_r;
          CKS_EXT: tick = ext_edge & pfn_r[PFN_EXT];
          default: tick = 1'b0;
        endcase
        cnt_en = start_r[START_RUN_LSB+gi] & tick;
        for (int j = 0; j < 4; j++) begin
          match[j] = cnt_en && (cnt_r[gi] == gr_r[gi][j]);
        end
        case (cfg_r[gi].ctrl[CTRL_CLR_LSB +: 2])
          CLR_ON_A: clr = match[0];
          CLR_ON_B: clr = match[1];
          default: clr = 1'b0;
        endcase
        // counter
        cnt_nxt = cnt_r[gi];
        if (cnt_wr_w[gi]) begin
          cnt_nxt = pwdata[15:0];
        end else if (clr) begin
          cnt_nxt = CNT_ZERO;
        end else if (cnt_en) begin
          cnt_nxt = 16'(cnt_r[gi] + 16'h0001);
        end
        ovf_nxt = cnt_en && (cnt_r[gi] == CNT_TOP);
        irqm_nxt = match;
        // config and compare registers
        cfg_nxt = cfg_r[gi];
        for (int j = 0; j < 4; j++) begin
          gr_nxt[j] = gr_r[gi][j];
        end
        if (wr_go && blk_hit_w[gi]) begin
          case (sub)
            SUB_CTRL: cfg_nxt.ctrl = pwdata[7:0];
            SUB_IOAB: cfg_nxt.ioab = pwdata[7:0];
            SUB_IOCD: cfg_nxt.iocd = pwdata[7:0];
            SUB_CNT: ;
            default: gr_nxt[sub[1:0]] = pwdata[15:0];
          endcase
        end
        // pin levels; a stopped timer sees no match, so levels hold
        lvl_nxt = lvl_r[gi];
        if (start_w[gi]) begin
          lvl_nxt = init_r[4*gi +: 4];
        end else begin
          if (match[0]) begin
            lvl_nxt[0] = act(cfg_r[gi].ioab[1:0], lvl_r[gi][0]);
          end else if (match[2] && redir_c) begin
            lvl_nxt[0] = act(cfg_r[gi].iocd[1:0], lvl_r[gi][0]);
          end
          if (match[1]) begin
            lvl_nxt[1] = act(cfg_r[gi].ioab[5:4], lvl_r[gi][1]);
          end else if (match[3] && redir_d) begin
            lvl_nxt[1] = act(cfg_r[gi].iocd[5:4], lvl_r[gi][1]);
          end
          // channels c/d drive their own pins only when not redirected or buffered
          if (match[2] && cfg_r[gi].iocd[3] && !mode_r[MODE_BUF_LSB+2*gi]) begin
            lvl_nxt[2] = act(cfg_r[gi].iocd[1:0], lvl_r[gi][2]);
          end
          if (match[3] && cfg_r[gi].iocd[7] && !mode_r[MODE_BUF_LSB+2*gi+1]) begin
            lvl_nxt[3] = act(cfg_r[gi].iocd[5:4], lvl_r[gi][3]);
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          cfg_r[gi] <= RST_CFG;
          cnt_r[gi] <= CNT_ZERO;
          lvl_r[gi] <= 4'h0;
          irqm_r[gi] <= 4'h0;
          ovf_r[gi] <= 1'b0;
          for (int j = 0; j < 4; j++) begin
            gr_r[gi][j] <= CNT_TOP;
          end
        end else begin
          cfg_r[gi] <= cfg_nxt;
          cnt_r[gi] <= cnt_nxt;
          lvl_r[gi] <= lvl_nxt;
          irqm_r[gi] <= irqm_nxt;
          ovf_r[gi] <= ovf_nxt;
          for (int j = 0; j < 4; j++) begin
            gr_r[gi][j] <= gr_nxt[j];
          end
        end
      end

      // checks
      // a counter write in the wrap cycle wins, so it is left out here
      ovf_pulse_a: assert property (ovf_nxt && !cnt_wr_w[gi]
        |=> ovf_r[gi] && cnt_r[gi] == CNT_ZERO)
        else $error("overflow not flagged or counter not wrapped");
      clear_match_a: assert property (clr && !cnt_wr_w[gi] |=> cnt_r[gi] == CNT_ZERO)
        else $error("counter not cleared on selected match");
      self_stop_a: assert property (stop_w[gi] |=> !start_r[START_RUN_LSB+gi])
        else $error("timer kept running after compare-a match");
      count_up_a: assert property (cnt_en && !clr && !cnt_wr_w[gi]
        |=> cnt_r[gi] == 16'($past(cnt_r[gi]) + 16'h0001))
        else $error("counter did not increment");
      init_level_a: assert property (start_w[gi] |=> lvl_r[gi] == $past(init_r[4*gi +: 4]))
        else $error("initial level not loaded at start");
      hold_stop_a: assert property (!start_r[START_RUN_LSB+gi] && !start_w[gi]
        |=> $stable(lvl_r[gi]))
        else $error("pin level moved while stopped");
      toggle_a_a: assert property (match[0] && cfg_r[gi].ioab[1:0] == ACT_TOGGLE
        && !start_w[gi] |=> lvl_r[gi][0] != $past(lvl_r[gi][0]))
        else $error("pin a did not toggle on match");
      match_irq_a: assert property (match[1] |=> irqm_r[gi][1]
        ##1 (!irqm_r[gi][1] || $past(match[1])))
        else $error("match request missing or not a pulse");
      redir_c_a: assert property (match[2] && redir_c && !match[0] && !start_w[gi]
        && cfg_r[gi].iocd[1:0] == ACT_TOGGLE |=> lvl_r[gi][0] != $past(lvl_r[gi][0]))
        else $error("redirected c did not invert pin a");
      low_b_a: assert property (match[1] && cfg_r[gi].ioab[5:4] == ACT_LOW && !start_w[gi]
        |=> !lvl_r[gi][1])
        else $error("pin b not driven low on match");
      cv_wrap: cover property (ovf_nxt ##1 cnt_en);
      cv_clear: cover property (clr ##[1:40] clr);
      cv_stop: cover property (stop_w[gi] ##1 start_w[gi]);
      cv_redir: cover property (match[2] && redir_c);
    end
  endgenerate

  sync_write_a: assert property (cnt_wr_w[0] && mode_r[MODE_SYNC]
    |=> cnt_r[0] == cnt_r[1])
    else $error("synchronised counter write left counters apart");
  pin_oe_a: assert property (dis_r[1] |=> !pin_oe[1])
    else $error("disabled pin still driven");
  ext_pin_a: assert property (pfn_r[PFN_EXT] |=> !pin_oe[0])
    else $error("pin a0 driven while used as clock input");

  // outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pin_out = {lvl_r[1], lvl_r[0]};
  assign pin_oe = oe_r;
  assign irq_match = {irqm_r[1], irqm_r[0]};
  assign irq_ovf = ovf_r;
  // the emergency cutoff pin has no input here: it only acts in pulse modes
endmodule : tmoc_timer
`default_nettype wire

/* File: tmoc_pins.sv */
/*
  pin-side model of the timer: resolves the pin wires and makes the
  external count clock on pin a0. assumes one clock, clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module tmoc_pins (
  // clock
  input wire logic clk_sys,
  // timer pins
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_in,
  // control from the bench
  input wire logic ext_en
);
  logic [1:0] div_r = 2'h0;
  logic clk_r = 1'b0;
  always @(posedge clk_sys) begin
    div_r <= div_r + 2'h1;
    // clock stands still while not in use
    if (!ext_en) begin
      clk_r <= 1'b0;
    end else if (div_r == 2'h3) begin
      clk_r <= ~clk_r;
    end
  end
  // pull-down on every pin that nobody drives
  assign pin_in[7:1] = pin_out[7:1] & pin_oe[7:1];
  assign pin_in[0] = ext_en ? clk_r : (pin_out[0] & pin_oe[0]);
endmodule : tmoc_pins
`default_nettype wire

/* File: tb_top.sv */
/*
  self-checking bench of the output-compare timer over apb.
  assumes tmoc_timer and the pin model tmoc_pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tmoc_pkg::*;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, err, lv, ext_en;
  tmoc_addr_t paddr;
  tmoc_word_t pwdata, prdata, rv, hv;
  logic [7:0] pin_in, pin_out, pin_oe, irq_match;
  logic [1:0] irq_ovf;
  logic [9:0] ev;
  int n_mismatch, comparisons, n, p;
  int divs [4] = '{2, 4, 8, 32};
  logic [2:0] cks [4] = '{CKS_DIV2, CKS_DIV4, CKS_DIV8, CKS_DIV32};
  assign ev = {irq_ovf, irq_match};
  tmoc_timer uut (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq_match(irq_match), .irq_ovf(irq_ovf));
  tmoc_pins far (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in), .ext_en(ext_en));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // idle cycle first, so psel is never assigned twice in one step
  task automatic xfer(input tmoc_addr_t a, input logic w, input tmoc_word_t d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) n_mismatch++;
  endtask : xfer
  task automatic wr(input tmoc_addr_t a, input tmoc_word_t d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rd(input tmoc_addr_t a);
    xfer(a, 1'b0, 32'h0);
  endtask : rd
  function automatic tmoc_addr_t ta(input int i, input logic [2:0] s);
    return tmoc_addr_t'(32 + i * 32 + int'(s) * 4);
  endfunction : ta
  task automatic wait_ev(input int i, output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (ev[i] !== 1'b1 && c < 70000);
    if (c >= 70000) n_mismatch++;
  endtask : wait_ev
  task automatic results;
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // whole run is about 70k cycles
  initial begin
    #5000000;
    n_mismatch++;
    results;
  end
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_en = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(OFS_START);
    chk("start reset", rv, 32'h0000000C);
    rd(ta(0, SUB_GRA));
    chk("compare a0 reset", rv, 32'h0000FFFF);
    rd(8'h80);
    chk("unmapped error", 32'(err), 32'h1);
    chk("unmapped data", rv, 32'h0);
    wr(ta(0, SUB_GRA), 32'h9);
    wr(ta(0, SUB_GRA + 3'h1), 32'h4);
    wr(ta(0, SUB_CTRL), 32'h08);
    wr(ta(0, SUB_IOAB), 32'h23);
    wr(OFS_INIT, 32'h01);
    wr(OFS_PFN, 32'h0F);
    wr(OFS_DIS, 32'hF0);
    wr(OFS_START, 32'hD);
    repeat (2) @(posedge clk_sys);
    chk("initial a0", 32'(pin_out[0]), 32'h1);
    chk("initial b0", 32'(pin_out[1]), 32'h0);
    chk("enable a0", 32'(pin_oe[0]), 32'h1);
    wait_ev(0, n);
    lv = pin_out[0];
    wait_ev(0, p);
    chk("period a0", p, 10);
    chk("toggle a0", 32'(pin_out[0]), 32'(!lv));
    chk("high b0", 32'(pin_out[1]), 32'h1);
    rd(ta(0, SUB_CNT));
    chk("count in range", 32'(rv < 10), 32'h1);
    wr(OFS_START, 32'hC);
    rd(ta(0, SUB_CNT));
    hv = rv;
    lv = pin_out[0];
    repeat (20) @(posedge clk_sys);
    rd(ta(0, SUB_CNT));
    chk("stopped count", rv, hv);
    chk("held a0", 32'(pin_out[0]), 32'(lv));
    wr(ta(0, SUB_CNT), 32'h0);
    wr(OFS_START, 32'h1);
    wait_ev(0, n);
    lv = pin_out[0];
    repeat (20) @(posedge clk_sys);
    rd(OFS_START);
    chk("run bit cleared", 32'(rv[0]), 32'h0);
    rd(ta(0, SUB_CNT));
    chk("count after match stop", rv, 32'h0);
    chk("held after match", 32'(pin_out[0]), 32'(lv));
    wr(ta(0, SUB_GRA), 32'h3);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_START, 32'hC);
      wr(ta(0, SUB_CTRL), 32'h08 | 32'(cks[k]));
      wr(OFS_START, 32'hD);
      wait_ev(0, n);
      wait_ev(0, p);
      chk("prescaled period", p, divs[k] * 4);
    end
    wr(OFS_START, 32'hC);
    wr(OFS_PFN, 32'h10F);
    wr(ta(0, SUB_CTRL), 32'h08 | 32'(CKS_EXT));
    ext_en <= 1'b1;
    wr(OFS_START, 32'hD);
    wait_ev(0, n);
    wait_ev(0, p);
    chk("external period", p, 32);
    chk("a0 as clock input", 32'(pin_oe[0]), 32'h0);
    wr(OFS_START, 32'hC);
    ext_en <= 1'b0;
    wr(OFS_PFN, 32'h0F);
    wr(ta(0, SUB_CTRL), 32'h08);
    wr(ta(0, SUB_GRA), 32'h9);
    // a and c kept distinct so both matches are seen
    wr(ta(0, SUB_GRA + 3'h2), 32'h5);
    wr(ta(0, SUB_IOAB), 32'h10);
    wr(OFS_INIT, 32'h03);
    wr(ta(0, SUB_IOCD), 32'h03);
    wr(OFS_START, 32'hD);
    wait_ev(2, n);
    lv = pin_out[0];
    wait_ev(2, p);
    chk("period c0", p, 10);
    chk("redirected a0", 32'(pin_out[0]), 32'(!lv));
    chk("low b0", 32'(pin_out[1]), 32'h0);
    wr(OFS_DIS, 32'hF1);
    repeat (2) @(posedge clk_sys);
    chk("disabled a0", 32'(pin_oe[0]), 32'h0);
    chk("enabled b0", 32'(pin_oe[1]), 32'h1);
    wait_ev(0, n);
    chk("internal match", 32'(n <= 11), 32'h1);
    wr(OFS_START, 32'hC);
    wr(OFS_MODE, 32'h1);
    wr(ta(0, SUB_CNT), 32'h1234);
    rd(ta(1, SUB_CNT));
    chk("paired load", rv, 32'h1234);
    wr(OFS_MODE, 32'h0);
    wr(ta(1, SUB_CNT), 32'h55);
    rd(ta(0, SUB_CNT));
    chk("own load t0", rv, 32'h1234);
    rd(ta(1, SUB_CNT));
    chk("own load t1", rv, 32'h55);
    wr(ta(1, SUB_CTRL), 32'h00);
    wr(ta(1, SUB_CNT), 32'hFFF0);
    wr(OFS_START, 32'hE);
    wait_ev(9, n);
    chk("match at ffff", 32'(irq_match[4]), 32'h1);
    chk("overflow delay", 32'(n >= 14 && n <= 20), 32'h1);
    wait_ev(9, p);
    chk("free period", p, 65536);
    results;
  end
endmodule : tb_top
`default_nettype wire
